// >>> verilog/rzc_pkg.sv
// Package of the reducer automatic zoom control.
// Assumes one register port on the pixel clock, 9-bit register offsets and 16-bit data.
package rzc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [8:0] RZC_ADDR_CUR_W = 9'h1ab;
  localparam logic [8:0] RZC_ADDR_CUR_H = 9'h1ac;
  localparam logic [8:0] RZC_ADDR_STEP = 9'h1ae;
  localparam logic [8:0] RZC_ADDR_CTRL = 9'h1af;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [15:0] RZC_STEP_RST = 16'h0504;
  localparam logic [15:0] RZC_CTRL_RST = 16'h0010;
  localparam logic [15:0] RZC_CTRL_WMASK = 16'h0378;
  localparam logic [10:0] RZC_FULL_W = 11'h500;
  localparam logic [10:0] RZC_FULL_H = 11'h400;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RZC_STEP_X_HI = 15;
  localparam int RZC_STEP_X_LO = 8;
  localparam int RZC_STEP_Y_HI = 7;
  localparam int RZC_STEP_Y_LO = 0;
  localparam int RZC_BIT_ZOOM_OUT = 9;
  localparam int RZC_BIT_ZOOM_IN = 8;
  localparam int RZC_BIT_AUTO_CLASSIC = 3;

  typedef struct packed {
    logic [15:0] step;
    logic [15:0] ctrl;
    logic [10:0] width;
    logic [10:0] height;
    logic [15:0] rdata;
    logic classic;
  } rzc_state_t;

endpackage

// >>> verilog/rzc_stepper.sv
// One axis of the zoom window: next size after one step, clamped to its limits.
// Assumes lo is not above hi; software keeps the window no smaller than the output.
`timescale 1ns/1ps
module rzc_stepper
  import rzc_pkg::*;
(
  input wire logic [10:0] cur,
  input wire logic [7:0] step,
  input wire logic grow,
  input wire logic [10:0] lo,
  input wire logic [10:0] hi,
  output logic [10:0] nxt,
  output logic at_hi,
  output logic at_lo
);

  logic [11:0] sum;
  logic [11:0] dif;

  always_comb begin
    sum = {1'b0, cur} + {4'h0, step};
    dif = {1'b0, cur} - {4'h0, step};
    if (grow) begin
      if (sum > {1'b0, hi}) begin
        nxt = hi;
      end else begin
        nxt = sum[10:0];
      end
    end else begin
      // Underflow or below output size stops at the lower limit
      if (dif[11] || (dif[10:0] < lo)) begin
        nxt = lo;
      end else begin
        nxt = dif[10:0];
      end
    end
    at_hi = (cur >= hi);
    at_lo = (cur <= lo);
  end

endmodule

// >>> verilog/rzc_top.sv
// Reducer automatic zoom control: step and control registers, zoom window state.
// Assumes frame_start and the output sizes come from logic on ref_clk.
//
// Behaviour
// - Step register holds X step in upper byte, Y step in lower byte.
// - Zoom-out bit starts automatic zoom out, window grows by the steps.
// - Zoom-in bit starts automatic zoom in, window shrinks by the steps.
// - Auto-switch bit selects classic interpolation at full resolution.
// - Current window width and height read back as 11-bit values.
`timescale 1ns/1ps
module rzc_top
  import rzc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [8:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic frame_start,
  input wire logic [10:0] out_width,
  input wire logic [10:0] out_height,
  output logic [10:0] cur_width,
  output logic [10:0] cur_height,
  output logic classic_interp
);

  // ****************************************
  // State and axis steppers
  // ****************************************
  rzc_state_t s_q;
  rzc_state_t s_d;

  logic zoom_out;
  logic zoom_in;
  logic active;
  logic grow;
  logic [10:0] nxt_w;
  logic [10:0] nxt_h;
  logic w_hi;
  logic w_lo;
  logic h_hi;
  logic h_lo;
  logic done;
  logic full_res;

  assign zoom_out = s_q.ctrl[RZC_BIT_ZOOM_OUT];
  assign zoom_in = s_q.ctrl[RZC_BIT_ZOOM_IN];
  assign active = zoom_out || zoom_in;
  assign grow = zoom_out;

  // Lower limit is the output size
  rzc_stepper u_step_x (
    .cur(s_q.width),
    .step(s_q.step[RZC_STEP_X_HI:RZC_STEP_X_LO]),
    .grow(grow),
    .lo(out_width),
    .hi(RZC_FULL_W),
    .nxt(nxt_w),
    .at_hi(w_hi),
    .at_lo(w_lo)
  );

  rzc_stepper u_step_y (
    .cur(s_q.height),
    .step(s_q.step[RZC_STEP_Y_HI:RZC_STEP_Y_LO]),
    .grow(grow),
    .lo(out_height),
    .hi(RZC_FULL_H),
    .nxt(nxt_h),
    .at_hi(h_hi),
    .at_lo(h_lo)
  );

  // Finished once both axes stand at the limit in the zoom direction
  assign done = grow ? (w_hi && h_hi) : (w_lo && h_lo);
  assign full_res = (s_q.width == RZC_FULL_W) && (s_q.height == RZC_FULL_H);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    // Automatic zoom, one step per frame
    if (active && frame_start) begin
      if (done) begin
        // Zoom out has priority; only its bit clears when both are set
        if (grow) begin
          s_d.ctrl[RZC_BIT_ZOOM_OUT] = 1'b0;
        end else begin
          s_d.ctrl[RZC_BIT_ZOOM_IN] = 1'b0;
        end
      end else begin
        s_d.width = nxt_w;
        s_d.height = nxt_h;
      end
    end
    // Register writes; a software set wins over the hardware clear
    if (reg_wr) begin
      if (reg_addr == RZC_ADDR_STEP) begin
        s_d.step = reg_wdata;
      end else if (reg_addr == RZC_ADDR_CTRL) begin
        s_d.ctrl = reg_wdata & RZC_CTRL_WMASK;
      end
    end
    s_d.classic = s_q.ctrl[RZC_BIT_AUTO_CLASSIC] && full_res;
    // Read data, one cycle after the address
    if (reg_addr == RZC_ADDR_CUR_W) begin
      s_d.rdata = {5'h00, s_q.width};
    end else if (reg_addr == RZC_ADDR_CUR_H) begin
      s_d.rdata = {5'h00, s_q.height};
    end else if (reg_addr == RZC_ADDR_STEP) begin
      s_d.rdata = s_q.step;
    end else if (reg_addr == RZC_ADDR_CTRL) begin
      s_d.rdata = s_q.ctrl;
    end else begin
      s_d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q.step <= RZC_STEP_RST;
      s_q.ctrl <= RZC_CTRL_RST;
      s_q.width <= RZC_FULL_W;
      s_q.height <= RZC_FULL_H;
      s_q.rdata <= 16'h0000;
      s_q.classic <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign cur_width = s_q.width;
  assign cur_height = s_q.height;
  assign classic_interp = s_q.classic;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Expected zoom-out sizes from the registers
  logic [11:0] chk_w_sum;
  logic [11:0] chk_h_sum;
  logic [10:0] chk_w_grow;
  logic [10:0] chk_h_grow;
  assign chk_w_sum = {1'b0, s_q.width} + {4'h0, s_q.step[RZC_STEP_X_HI:RZC_STEP_X_LO]};
  assign chk_h_sum = {1'b0, s_q.height} + {4'h0, s_q.step[RZC_STEP_Y_HI:RZC_STEP_Y_LO]};
  assign chk_w_grow = (chk_w_sum > {1'b0, RZC_FULL_W}) ? RZC_FULL_W : chk_w_sum[10:0];
  assign chk_h_grow = (chk_h_sum > {1'b0, RZC_FULL_H}) ? RZC_FULL_H : chk_h_sum[10:0];

  sequence seq_out_step;
    zoom_out && frame_start && !reg_wr && !(w_hi && h_hi);
  endsequence

  sequence seq_in_step;
    !zoom_out && zoom_in && frame_start && !reg_wr && !(w_lo && h_lo);
  endsequence

  chk_step_write: assert property (
    reg_wr && reg_addr == RZC_ADDR_STEP |=> s_q.step == $past(reg_wdata))
    else $error("step register not loaded");

  chk_out_grow: assert property (
    seq_out_step |=> (s_q.width >= $past(s_q.width)) && (s_q.height >= $past(s_q.height))
      && ((s_q.width != $past(s_q.width)) || (s_q.height != $past(s_q.height))))
    else $error("zoom out did not grow window");

  chk_in_shrink: assert property (
    seq_in_step |=> (s_q.width <= $past(s_q.width)) && (s_q.height <= $past(s_q.height))
      && ((s_q.width != $past(s_q.width)) || (s_q.height != $past(s_q.height))))
    else $error("zoom in did not shrink window");

  chk_classic_full: assert property (
    ##1 classic_interp == ($past(s_q.ctrl[RZC_BIT_AUTO_CLASSIC])
      && $past(cur_width) == RZC_FULL_W && $past(cur_height) == RZC_FULL_H))
    else $error("classic interpolation select wrong");

  chk_read_width: assert property (
    reg_addr == RZC_ADDR_CUR_W |=> reg_rdata == {5'h00, $past(cur_width)})
    else $error("width readback wrong");

  chk_read_height: assert property (
    reg_addr == RZC_ADDR_CUR_H |=> reg_rdata == {5'h00, $past(cur_height)})
    else $error("height readback wrong");

  chk_no_frame_hold: assert property (
    !frame_start |=> $stable(cur_width) && $stable(cur_height))
    else $error("window changed without frame boundary");

  chk_out_clear: assert property (
    zoom_out && frame_start && !reg_wr && w_hi && h_hi
      |=> !s_q.ctrl[RZC_BIT_ZOOM_OUT] && $stable(cur_width))
    else $error("zoom out bit not cleared at limit");

  chk_in_clear: assert property (
    !zoom_out && zoom_in && frame_start && !reg_wr && w_lo && h_lo
      |=> !s_q.ctrl[RZC_BIT_ZOOM_IN] && $stable(cur_height))
    else $error("zoom in bit not cleared at limit");

  chk_ctrl_write: assert property (
    reg_wr && reg_addr == RZC_ADDR_CTRL |=> s_q.ctrl == ($past(reg_wdata) & RZC_CTRL_WMASK))
    else $error("control register not loaded");

  chk_read_step: assert property (
    reg_addr == RZC_ADDR_STEP |=> reg_rdata == $past(s_q.step))
    else $error("step readback wrong");

  chk_window_max: assert property (
    cur_width <= RZC_FULL_W && cur_height <= RZC_FULL_H)
    else $error("window beyond full resolution");

  chk_in_floor: assert property (
    !zoom_out && zoom_in && frame_start && !(w_lo && h_lo)
      |=> cur_width >= $past(out_width) && cur_height >= $past(out_height))
    else $error("zoom in went below output size");

  chk_out_exact: assert property (
    seq_out_step |=> cur_width == $past(chk_w_grow) && cur_height == $past(chk_h_grow))
    else $error("zoom out step size wrong");

endmodule

// >>> bench/tb_reducer_auto_zoom_control.sv
// Self-checking bench of the reducer automatic zoom control.
// Assumes rzc_pkg and rzc_top compiled first; the bench drives all inputs at falling edges.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_reducer_auto_zoom_control;
  import rzc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic frame_start = 1'b0;
  logic [10:0] out_width = 11'h4f0;
  logic [10:0] out_height = 11'h3f8;
  logic [10:0] cur_width;
  logic [10:0] cur_height;
  logic classic_interp;
  int num_errors = 0;
  int checked = 0;

  rzc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .out_width(out_width), .out_height(out_height), .cur_width(cur_width),
    .cur_height(cur_height), .classic_interp(classic_interp));

  always #4 ref_clk = ~ref_clk;

  // ****************************************
  // Register port, frame and end-of-test tasks
  // ****************************************
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] ex, input string nm);
    reg_addr = a;
    @(negedge ref_clk);
    @(negedge ref_clk);
    `CHK(nm, ex, reg_rdata)
  endtask

  task automatic frame(input logic [10:0] ew, input logic [10:0] eh);
    @(negedge ref_clk);
    frame_start = 1'b1;
    @(negedge ref_clk);
    frame_start = 1'b0;
    `CHK("cur_width", ew, cur_width)
    `CHK("cur_height", eh, cur_height)
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    rd(RZC_ADDR_STEP, 16'h0504, "step reset");
    rd(RZC_ADDR_CTRL, 16'h0010, "ctrl reset");
    rd(RZC_ADDR_CUR_W, 16'h0500, "width reset");
    rd(RZC_ADDR_CUR_H, 16'h0400, "height reset");
    rd(9'h1ad, 16'h0000, "unmapped");
    wr(RZC_ADDR_CUR_W, 16'h0123);
    rd(RZC_ADDR_CUR_W, 16'h0500, "width read only");
    wr(RZC_ADDR_STEP, 16'h0a08);
    rd(RZC_ADDR_STEP, 16'h0a08, "step write");
    wr(RZC_ADDR_CTRL, 16'hffff);
    rd(RZC_ADDR_CTRL, 16'h0378, "ctrl mask");
    wr(RZC_ADDR_CTRL, 16'h0000);
    frame(11'h500, 11'h400);
    // Zoom in: width reaches its floor a frame after height
    wr(RZC_ADDR_CTRL, 16'h0100);
    frame(11'h4f6, 11'h3f8);
    frame(11'h4f0, 11'h3f8);
    rd(RZC_ADDR_CTRL, 16'h0100, "ctrl zoom in busy");
    frame(11'h4f0, 11'h3f8);
    rd(RZC_ADDR_CTRL, 16'h0000, "ctrl zoom in done");
    rd(RZC_ADDR_CUR_W, 16'h04f0, "width after zoom in");
    `CHK("classic off", 1'b0, classic_interp)
    // Zoom out with the classic switch enabled
    wr(RZC_ADDR_CTRL, 16'h0208);
    frame(11'h4fa, 11'h400);
    `CHK("classic below full", 1'b0, classic_interp)
    frame(11'h500, 11'h400);
    @(negedge ref_clk);
    `CHK("classic at full", 1'b1, classic_interp)
    frame(11'h500, 11'h400);
    rd(RZC_ADDR_CTRL, 16'h0008, "ctrl zoom out done");
    wr(RZC_ADDR_CTRL, 16'h0000);
    repeat (2) @(negedge ref_clk);
    `CHK("classic disabled", 1'b0, classic_interp)
    // Both command bits: zoom out wins, window already full
    wr(RZC_ADDR_CTRL, 16'h0300);
    frame(11'h500, 11'h400);
    rd(RZC_ADDR_CTRL, 16'h0100, "ctrl out cleared first");
    end_of_test();
  end
endmodule
